// file: verilog/sss_core.v
// Setpoint, protection and auto-sequence core of a programmable supply
// Behaviour
// - Pending triggered voltage and current load into active setpoints on trigger.
// - Immediate writes leave pending triggered levels untouched until trigger or abort.
// - Triggered-level commands act only while the trigger system is initiated.
// - Triggered query returns immediate level when no triggered level programmed.
// - MAX or MIN qualified setpoint queries return the programmable bounds.
// - Voltage above trip level disables output, sets questionable bit 0.
// - Over-voltage trip clears only by protection clear command.
// - Current above trip level disables output, sets questionable bit 1.
// - Over-current trip clears only by protection clear command.
// - Dwell period accepted from 10 ms up to 163.83 s (code 16383, the 14-bit field limit).
// - Period code 0 in a sequence stops it like a stop command.
// - Period code 9998 makes the next location zero.
// - Period code 9999 holds the location until a stop command.
// - Memory select sets location; 0-99 remote, 0-9 local.
// - Operation status word is read-only and live.
// - Operation bits 0..11 as listed; bits 12-15 read zero.
// - Abort cancels trigger action, pending levels return to immediate values.
// - Output will not restart until fault gone and alarm cleared.
// - Stepping past location 99 wraps to location 0 and continues.
`timescale 1ns/1ps
`include "sss_consts.vh"
module sss_core #(
  parameter LW = 16,
  parameter [LW-1:0] V_MAX = 16'hffff,
  parameter [LW-1:0] V_MIN = 16'h0000,
  parameter [LW-1:0] I_MAX = 16'hffff,
  parameter [LW-1:0] I_MIN = 16'h0000,
  parameter [LW-1:0] OVT_MAX = 16'hffff,
  parameter [LW-1:0] OVT_MIN = 16'h0000,
  parameter [LW-1:0] OCT_MAX = 16'hffff,
  parameter [LW-1:0] OCT_MIN = 16'h0000,
  parameter UNIT_CYCLES = `SSS_PER_UNIT_NS / `SSS_CLK_NS
) (
  input wire ref_clk,
  input wire rst_n,
  input wire cmd_valid,
  input wire [3:0] cmd_code,
  input wire [LW-1:0] cmd_value,
  input wire qry_valid,
  input wire [2:0] qry_sel,
  input wire [1:0] qry_qual,
  input wire local_mode,
  input wire init_continuous,
  input wire [LW-1:0] meas_voltage,
  input wire [LW-1:0] meas_current,
  input wire soft_start_flag,
  input wire locked_flag,
  input wire internal_control_flag,
  input wire external_control_flag,
  input wire standby_flag,
  input wire constant_voltage_flag,
  input wire remote_sense_flag,
  input wire constant_current_flag,
  output reg qry_ready,
  output reg [LW-1:0] qry_data,
  output reg cmd_error,
  output reg [LW-1:0] voltage_setpoint,
  output reg [LW-1:0] current_setpoint,
  output reg output_enable,
  output reg [15:0] questionable_condition_status,
  output reg [15:0] operation_condition_status
);
  localparam DW = 3 * LW + 14 + LW;
  // Longest dwell in 10 ms units; the 14-bit code field caps what is kept
  localparam [31:0] PER_MAX = `SSS_PER_MAX_SEC * 100;
  localparam [LW-1:0] PER_TOP = {{(LW-14){1'b0}}, {14{1'b1}}};
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_LOAD = 2'd1;
  localparam [1:0] ST_RUN = 2'd2;
  localparam [1:0] ST_HOLD = 2'd3;

  reg [LW-1:0] volt_imm_r, curr_imm_r, triggered_voltage_command_r, triggered_current_command_r;
  reg triggered_voltage_command_set_r, triggered_current_command_set_r;
  reg [LW-1:0] overvoltage_trip_level_r, overcurrent_trip_level_r;
  reg [13:0] period_r;
  reg [6:0] mem_loc_r;
  reg overvoltage_tripped_flag_r, overcurrent_tripped_flag_r;
  reg initiated_r, armed_r, running_r;
  reg [1:0] state_r;
  reg [31:0] unit_cnt_r;
  reg [13:0] dwell_cnt_r;
  reg wrap_next_r;
  wire [DW-1:0] rd_data;
  wire [6:0] next_loc;
  wire [6:0] rd_loc;
  wire [LW-1:0] mv_s, mc_s;
  wire [7:0] flags_s;
  wire store_en;
  wire ov_now, oc_now;

  // Meter readings and status pins come from outside the clock domain
  sss_sync #(.W(2 * LW + 8)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d({meas_voltage, meas_current, soft_start_flag, locked_flag,
        internal_control_flag, external_control_flag, standby_flag,
        constant_voltage_flag, remote_sense_flag, constant_current_flag}),
    .q({mv_s, mc_s, flags_s})
  );

  // Store snapshot of present settings into the current location
  assign store_en = cmd_valid && (cmd_code == `SSS_CMD_STORE);

  sss_step_mem #(.DW(DW), .AW(7), .DEPTH(100)) u_mem (
    .ref_clk(ref_clk),
    .wr_en(store_en),
    .wr_addr(mem_loc_r),
    .wr_data({volt_imm_r, curr_imm_r, overvoltage_trip_level_r,
              period_r, overcurrent_trip_level_r}),
    .rd_addr(rd_loc),
    .rd_data(rd_data)
  );

  // Next location, wrapping after the last one
  function [6:0] step_loc;
    input [6:0] loc;
    input wrap;
    begin
      if (wrap || loc >= `SSS_MEM_LAST)
        step_loc = 7'h00;
      else
        step_loc = loc + 7'h01;
    end
  endfunction

  assign next_loc = step_loc(mem_loc_r, wrap_next_r);
  // While dwelling, prefetch the next location so the load sees its data
  assign rd_loc = (state_r == ST_RUN) ? next_loc : mem_loc_r;
  assign ov_now = mv_s > overvoltage_trip_level_r;
  assign oc_now = mc_s > overcurrent_trip_level_r;

  // Command interpreter, trip latches and auto-sequence engine
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      volt_imm_r <= {LW{1'b0}};
      curr_imm_r <= {LW{1'b0}};
      triggered_voltage_command_r <= {LW{1'b0}};
      triggered_current_command_r <= {LW{1'b0}};
      triggered_voltage_command_set_r <= 1'b0;
      triggered_current_command_set_r <= 1'b0;
      overvoltage_trip_level_r <= OVT_MAX;
      overcurrent_trip_level_r <= OCT_MAX;
      period_r <= `SSS_PER_STOP;
      mem_loc_r <= 7'h00;
      overvoltage_tripped_flag_r <= 1'b0;
      overcurrent_tripped_flag_r <= 1'b0;
      initiated_r <= 1'b0;
      armed_r <= 1'b0;
      running_r <= 1'b0;
      state_r <= ST_IDLE;
      unit_cnt_r <= 32'h0000_0000;
      dwell_cnt_r <= 14'h0000;
      wrap_next_r <= 1'b0;
      cmd_error <= 1'b0;
    end
    else
    begin
      cmd_error <= 1'b0;
      // Trip latches: set wins over clear
      if (cmd_valid && cmd_code == `SSS_CMD_CLEAR)
      begin
        overvoltage_tripped_flag_r <= ov_now;
        overcurrent_tripped_flag_r <= oc_now;
      end
      else
      begin
        if (ov_now)
          overvoltage_tripped_flag_r <= 1'b1;
        if (oc_now)
          overcurrent_tripped_flag_r <= 1'b1;
      end
      if (init_continuous && !initiated_r)
        initiated_r <= 1'b1;
      if (cmd_valid)
      begin
        case (cmd_code)
          `SSS_CMD_VOLT: volt_imm_r <= cmd_value;
          `SSS_CMD_CURR: curr_imm_r <= cmd_value;
          `SSS_CMD_TRIGGERED_VOLTAGE_COMMAND:
            if (initiated_r)
            begin
              triggered_voltage_command_r <= cmd_value;
              triggered_voltage_command_set_r <= 1'b1;
            end
          `SSS_CMD_TRIGGERED_CURRENT_COMMAND:
            if (initiated_r)
            begin
              triggered_current_command_r <= cmd_value;
              triggered_current_command_set_r <= 1'b1;
            end
          `SSS_CMD_OVT: overvoltage_trip_level_r <= cmd_value;
          `SSS_CMD_OCT: overcurrent_trip_level_r <= cmd_value;
          `SSS_CMD_PER:
            // Reserved codes 0, 9998 and 9999 lie inside this range
            if (cmd_value <= PER_TOP && cmd_value <= PER_MAX)
              period_r <= cmd_value[13:0];
            else
              cmd_error <= 1'b1;
          `SSS_CMD_MEM:
            if (cmd_value <= {9'h000, local_mode ? `SSS_MEM_LAST_LOCAL
                                                 : `SSS_MEM_LAST})
              mem_loc_r <= cmd_value[6:0];
            else
              cmd_error <= 1'b1;
          `SSS_CMD_INIT: initiated_r <= 1'b1;
          `SSS_CMD_TRIG:
            if (initiated_r)
            begin
              if (triggered_voltage_command_set_r)
                volt_imm_r <= triggered_voltage_command_r;
              if (triggered_current_command_set_r)
                curr_imm_r <= triggered_current_command_r;
              triggered_voltage_command_set_r <= 1'b0;
              triggered_current_command_set_r <= 1'b0;
              initiated_r <= init_continuous;
            end
          `SSS_CMD_ABORT:
          begin
            triggered_voltage_command_set_r <= 1'b0;
            triggered_current_command_set_r <= 1'b0;
            triggered_voltage_command_r <= volt_imm_r;
            triggered_current_command_r <= curr_imm_r;
            initiated_r <= init_continuous;
          end
          `SSS_CMD_START:
            if (!overvoltage_tripped_flag_r && !overcurrent_tripped_flag_r &&
                !ov_now && !oc_now)
            begin
              running_r <= 1'b1;
              if (armed_r)
                state_r <= ST_LOAD;
            end
            else
              cmd_error <= 1'b1;
          `SSS_CMD_STOP:
          begin
            running_r <= 1'b0;
            state_r <= ST_IDLE;
          end
          `SSS_CMD_STORE: armed_r <= cmd_value[0];
          default: cmd_error <= 1'b0;
        endcase
      end
      // Auto-sequence engine; read data ready one cycle after address
      case (state_r)
        ST_IDLE: wrap_next_r <= 1'b0;
        ST_LOAD:
          if (rd_data[LW +: 14] == `SSS_PER_STOP)
          begin
            running_r <= 1'b0;
            state_r <= ST_IDLE;
          end
          else
          begin
            volt_imm_r <= rd_data[DW-1 -: LW];
            curr_imm_r <= rd_data[DW-LW-1 -: LW];
            overvoltage_trip_level_r <= rd_data[LW+14 +: LW];
            overcurrent_trip_level_r <= rd_data[LW-1:0];
            period_r <= rd_data[LW +: 14];
            wrap_next_r <= rd_data[LW +: 14] == `SSS_PER_WRAP;
            dwell_cnt_r <= rd_data[LW +: 14];
            unit_cnt_r <= 32'h0000_0000;
            state_r <= (rd_data[LW +: 14] == `SSS_PER_HOLD) ? ST_HOLD
                                                            : ST_RUN;
          end
        ST_RUN:
          if (unit_cnt_r == UNIT_CYCLES - 1)
          begin
            unit_cnt_r <= 32'h0000_0000;
            if (dwell_cnt_r <= 14'h0001 ||
                dwell_cnt_r == `SSS_PER_WRAP)
            begin
              mem_loc_r <= next_loc;
              state_r <= ST_LOAD;
            end
            else
              dwell_cnt_r <= dwell_cnt_r - 14'h0001;
          end
          else
            unit_cnt_r <= unit_cnt_r + 32'h0000_0001;
        ST_HOLD: state_r <= ST_HOLD;
        default: state_r <= ST_IDLE;
      endcase
      if (!running_r || overvoltage_tripped_flag_r ||
          overcurrent_tripped_flag_r)
        if (state_r != ST_IDLE && !(cmd_valid && cmd_code ==
            `SSS_CMD_START))
          state_r <= ST_IDLE;
      if (overvoltage_tripped_flag_r || overcurrent_tripped_flag_r ||
          ov_now || oc_now)
        running_r <= 1'b0;
    end
  end

  // Registered query answers and live status words
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      qry_ready <= 1'b0;
      qry_data <= {LW{1'b0}};
      voltage_setpoint <= {LW{1'b0}};
      current_setpoint <= {LW{1'b0}};
      output_enable <= 1'b0;
      questionable_condition_status <= 16'h0000;
      operation_condition_status <= 16'h0000;
    end
    else
    begin
      qry_ready <= qry_valid;
      if (qry_valid)
      begin
        case (qry_sel)
          `SSS_Q_VOLT, `SSS_Q_TRIGGERED_VOLTAGE_COMMAND:
            qry_data <= (qry_qual == `SSS_QUAL_MAX) ? V_MAX :
                        (qry_qual == `SSS_QUAL_MIN) ? V_MIN :
                        (qry_sel == `SSS_Q_TRIGGERED_VOLTAGE_COMMAND && triggered_voltage_command_set_r) ?
                        triggered_voltage_command_r : volt_imm_r;
          `SSS_Q_CURR, `SSS_Q_TRIGGERED_CURRENT_COMMAND:
            qry_data <= (qry_qual == `SSS_QUAL_MAX) ? I_MAX :
                        (qry_qual == `SSS_QUAL_MIN) ? I_MIN :
                        (qry_sel == `SSS_Q_TRIGGERED_CURRENT_COMMAND && triggered_current_command_set_r) ?
                        triggered_current_command_r : curr_imm_r;
          `SSS_Q_OVT:
            qry_data <= (qry_qual == `SSS_QUAL_MAX) ? OVT_MAX :
                        (qry_qual == `SSS_QUAL_MIN) ? OVT_MIN :
                        overvoltage_trip_level_r;
          `SSS_Q_OCT:
            qry_data <= (qry_qual == `SSS_QUAL_MAX) ? OCT_MAX :
                        (qry_qual == `SSS_QUAL_MIN) ? OCT_MIN :
                        overcurrent_trip_level_r;
          `SSS_Q_PER:
            qry_data <= (qry_qual == `SSS_QUAL_MAX) ? PER_TOP :
                        (qry_qual == `SSS_QUAL_MIN) ? {{(LW-1){1'b0}}, 1'b1} :
                        {2'b00, period_r};
          default: qry_data <= {9'h000, mem_loc_r};
        endcase
      end
      voltage_setpoint <= volt_imm_r;
      current_setpoint <= curr_imm_r;
      output_enable <= running_r && !overvoltage_tripped_flag_r &&
                       !overcurrent_tripped_flag_r && !ov_now && !oc_now;
      questionable_condition_status <= {14'h0000,
        overcurrent_tripped_flag_r, overvoltage_tripped_flag_r};
      // Live operation bits, upper nibble zero
      operation_condition_status <= {4'h0,
        flags_s[3] | overvoltage_tripped_flag_r | overcurrent_tripped_flag_r,
        flags_s[0], flags_s[1], flags_s[2], running_r, flags_s[3],
        initiated_r, flags_s[4], flags_s[5], flags_s[6], flags_s[7],
        armed_r};
    end
  end
endmodule // sss_core

// file: verilog/sss_consts.vh
// Constants for the supply setpoint sequencer
`ifndef SSS_CONSTS_VH
`define SSS_CONSTS_VH
// Command codes on the command port
`define SSS_CMD_W 4
`define SSS_CMD_VOLT 4'h1
`define SSS_CMD_TRIGGERED_VOLTAGE_COMMAND 4'h2
`define SSS_CMD_CURR 4'h3
`define SSS_CMD_TRIGGERED_CURRENT_COMMAND 4'h4
`define SSS_CMD_OVT 4'h5
`define SSS_CMD_OCT 4'h6
`define SSS_CMD_PER 4'h7
`define SSS_CMD_MEM 4'h8
`define SSS_CMD_CLEAR 4'h9
`define SSS_CMD_INIT 4'ha
`define SSS_CMD_TRIG 4'hb
`define SSS_CMD_ABORT 4'hc
`define SSS_CMD_START 4'hd
`define SSS_CMD_STOP 4'he
`define SSS_CMD_STORE 4'hf
// Query selectors
`define SSS_Q_VOLT 3'h0
`define SSS_Q_TRIGGERED_VOLTAGE_COMMAND 3'h1
`define SSS_Q_CURR 3'h2
`define SSS_Q_TRIGGERED_CURRENT_COMMAND 3'h3
`define SSS_Q_OVT 3'h4
`define SSS_Q_OCT 3'h5
`define SSS_Q_PER 3'h6
`define SSS_Q_MEM 3'h7
// Query qualifiers
`define SSS_QUAL_NONE 2'h0
`define SSS_QUAL_MAX 2'h1
`define SSS_QUAL_MIN 2'h2
// Period codes, unit 10 ms
`define SSS_PER_STOP 14'h0000
`define SSS_PER_WRAP 14'h270e
`define SSS_PER_HOLD 14'h270f
`define SSS_PER_MAX_SEC 9997
`define SSS_PER_UNIT_NS 10000000
`define SSS_CLK_NS 4
// Memory locations
`define SSS_MEM_LAST 7'h63
`define SSS_MEM_LAST_LOCAL 7'h09
// Questionable and operation bit positions
`define SSS_QB_OV 0
`define SSS_QB_OC 1
`define SSS_OB_ARM 0
`define SSS_OB_WTG 5
`define SSS_OB_PWR 7
`define SSS_OB_STANDBY_OR_ALARM_FLAG 11
`endif

// file: verilog/sss_step_mem.v
// Memory of auto-sequence locations with registered read data
`timescale 1ns/1ps
module sss_step_mem #(
  parameter DW = 78,
  parameter AW = 7,
  parameter DEPTH = 100
) (
  input wire ref_clk,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data
);
  reg [DW-1:0] mem [0:DEPTH-1];

  // Write port and registered read port
  always @(posedge ref_clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
    rd_data <= mem[rd_addr];
  end
endmodule // sss_step_mem

// file: verilog/sss_sync.v
// Three-stage synchroniser with second and third stage agreement
`timescale 1ns/1ps
module sss_sync #(
  parameter W = 1
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  genvar i;

  // Shift chain
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Output follows a bit only once two stages agree
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      always @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
          q[i] <= 1'b0;
        else if (s2_r[i] == s3_r[i])
          q[i] <= s3_r[i];
      end
    end
  endgenerate
endmodule // sss_sync

// file: tb/sss_core_monitor.sv
// Concurrent checks on the supply setpoint sequencer ports
`timescale 1ns/1ps
`include "sss_consts.vh"
module sss_core_monitor #(
  parameter [15:0] V_MAX = 16'hffff
) (
  input wire ref_clk,
  input wire rst_n,
  input wire cmd_valid,
  input wire [3:0] cmd_code,
  input wire [15:0] cmd_value,
  input wire qry_valid,
  input wire [1:0] qry_qual,
  input wire [2:0] qry_sel,
  input wire local_mode,
  input wire soft_start_flag,
  input wire qry_ready,
  input wire [15:0] qry_data,
  input wire cmd_error,
  input wire [15:0] voltage_setpoint,
  input wire output_enable,
  input wire [15:0] questionable_condition_status,
  input wire [15:0] operation_condition_status
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  logic [2:0] clr_r;
  // History of protection clear commands
  always @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      clr_r <= 3'h0;
    else
      clr_r <= {clr_r[1:0], cmd_valid && cmd_code == `SSS_CMD_CLEAR};
  // Immediate voltage write followed by an idle cycle
  sequence s_vset;
    cmd_valid && cmd_code == `SSS_CMD_VOLT &&
      !operation_condition_status[7] ##1 !cmd_valid;
  endsequence
  // Initiate followed by an idle cycle
  sequence s_init;
    cmd_valid && cmd_code == `SSS_CMD_INIT ##1 !cmd_valid;
  endsequence
  AST_VSET: assert property (s_vset |=>
    voltage_setpoint == $past(cmd_value, 2)) else $error("setpoint late");
  AST_WTG: assert property (s_init |=> operation_condition_status[5])
    else $error("waiting flag missing");
  AST_QANS: assert property (qry_valid |=> qry_ready)
    else $error("query unanswered");
  AST_QONLY: assert property (qry_ready |-> $past(qry_valid))
    else $error("spurious answer");
  AST_QMAX: assert property (qry_valid && qry_qual == `SSS_QUAL_MAX &&
    qry_sel <= 3'h1 |=> qry_data == V_MAX) else $error("bad max");
  AST_QUES: assert property (questionable_condition_status[15:2] == 14'h0)
    else $error("questionable bits");
  AST_OPNU: assert property (operation_condition_status[15:12] == 4'h0)
    else $error("unused bits set");
  AST_TRIP: assert property (|questionable_condition_status[1:0]
    |-> !output_enable) else $error("output on while tripped");
  AST_CLR: assert property ($fell(questionable_condition_status[0]) ||
    $fell(questionable_condition_status[1]) |-> |clr_r)
    else $error("trip dropped without clear");
  AST_MEMERR: assert property (cmd_valid && cmd_code == `SSS_CMD_MEM &&
    cmd_value > (local_mode ? 16'd9 : 16'd99) |=> cmd_error)
    else $error("bad location taken");
  AST_MEMOK: assert property (cmd_valid && cmd_code == `SSS_CMD_MEM &&
    cmd_value <= 16'd9 |=> !cmd_error) else $error("good location refused");
  AST_LIVE: assert property ($stable(soft_start_flag) [*8] |->
    operation_condition_status[1] == soft_start_flag)
    else $error("status not live");
endmodule // sss_core_monitor

// file: tb/sss_host.sv
// Host model issuing remote commands and queries
`timescale 1ns/1ps
module sss_host (
  input wire ref_clk,
  output logic cmd_valid,
  output logic [3:0] cmd_code,
  output logic [15:0] cmd_value,
  output logic qry_valid,
  output logic [2:0] qry_sel,
  output logic [1:0] qry_qual
);
  // Idle bus at time zero
  initial
  begin
    cmd_valid = 1'b0;
    cmd_code = 4'h0;
    cmd_value = 16'h0;
    qry_valid = 1'b0;
    qry_sel = 3'h0;
    qry_qual = 2'h0;
  end
  // One command strobe; operand scrambled once released
  task automatic cmd(input logic [3:0] k, input logic [15:0] v);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_code <= k;
    cmd_value <= v;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    cmd_value <= ~v;
  endtask
  // One query strobe
  task automatic qry(input logic [2:0] s, input logic [1:0] u);
    @(posedge ref_clk);
    qry_valid <= 1'b1;
    qry_sel <= s;
    qry_qual <= u;
    @(posedge ref_clk);
    qry_valid <= 1'b0;
    qry_sel <= ~s;
  endtask
endmodule // sss_host

// file: tb/tb_supply_setpoint_sequencer.sv
// Self-checking bench for the supply setpoint sequencer
`timescale 1ns/1ps
`include "sss_consts.vh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_supply_setpoint_sequencer;
  localparam [15:0] VMX = 16'h7fff, VMN = 16'h0001;
  localparam [15:0] IMX = 16'h3fff, IMN = 16'h0002;
  logic ref_clk, rst_n, local_mode, init_cont;
  logic [15:0] meas_voltage, meas_current, a, b, t, u, qe, eo;
  logic [7:0] flags;
  logic [15:0] exq[$];
  wire cmd_valid, qry_valid, qry_ready, cmd_error, output_enable;
  wire [3:0] cmd_code;
  wire [2:0] qry_sel;
  wire [1:0] qry_qual;
  wire [15:0] cmd_value, qdata, vset, iset, ques, oper;
  int errors, checks;
  sss_host sss_host_i (.ref_clk, .cmd_valid, .cmd_code, .cmd_value,
    .qry_valid, .qry_sel, .qry_qual);
  sss_core #(.V_MAX(VMX), .V_MIN(VMN), .I_MAX(IMX), .I_MIN(IMN),
    .UNIT_CYCLES(4)) sss_core_i (.ref_clk, .rst_n, .cmd_valid, .cmd_code,
    .cmd_value, .qry_valid, .qry_sel, .qry_qual, .local_mode,
    .init_continuous(init_cont), .meas_voltage, .meas_current,
    .soft_start_flag(flags[0]), .locked_flag(flags[1]),
    .internal_control_flag(flags[2]), .external_control_flag(flags[3]),
    .standby_flag(flags[4]), .constant_voltage_flag(flags[5]),
    .remote_sense_flag(flags[6]), .constant_current_flag(flags[7]),
    .qry_ready, .qry_data(qdata), .cmd_error, .voltage_setpoint(vset),
    .current_setpoint(iset), .output_enable,
    .questionable_condition_status(ques),
    .operation_condition_status(oper));
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic conclude;
    `CHK("pending", 32'h0, exq.size())
    if (errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Answers are matched against the oldest expectation
  always @(posedge ref_clk)
    if (qry_ready === 1'b1)
    begin
      qe = exq.size() ? exq.pop_front() : 16'hxxxx;
      `CHK("qry_data", qe, qdata)
    end
  function automatic logic [15:0] rnd();
    return 16'h0010 + 16'($urandom % 32'h3f00);
  endfunction
  task automatic c(input logic [3:0] k, input logic [15:0] v);
    sss_host_i.cmd(k, v);
  endtask
  task automatic q(input logic [2:0] s, input logic [1:0] l, input logic [15:0] e);
    exq.push_back(e);
    sss_host_i.qry(s, l);
  endtask
  // Command followed by a look at the refusal pulse
  task automatic ce(input logic [3:0] k, input logic [15:0] v, input logic e);
    c(k, v);
    #1;
    `CHK("cmd_error", e, cmd_error)
  endtask
  task automatic prog(input logic [6:0] l, input logic [15:0] v, p,
    input logic m);
    c(`SSS_CMD_MEM, {9'h0, l});
    c(`SSS_CMD_VOLT, v);
    c(`SSS_CMD_PER, p);
    c(`SSS_CMD_STORE, {15'h0, m});
  endtask
  // Bounded wait on the setpoint or, with o set, the output enable
  task automatic waitv(input logic [15:0] e, input bit o);
    logic [15:0] s;
    int n;
    n = 0;
    s = o ? {15'h0, output_enable} : vset;
    while (s !== e && n < 300)
    begin
      @(posedge ref_clk);
      #1;
      s = o ? {15'h0, output_enable} : vset;
      n++;
    end
    `CHK("wait", e, s)
    if (n >= 300)
      conclude();
  endtask
  initial
  begin
    rst_n = 1'b0;
    local_mode = 1'b0;
    init_cont = 1'b0;
    meas_voltage = 16'h0;
    meas_current = 16'h0;
    flags = 8'h0;
    errors = 0;
    checks = 0;
    void'($urandom(32'h96e32d0b));
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    q(`SSS_Q_OVT, `SSS_QUAL_NONE, 16'hffff);
    for (int s = 0; s < 4; s++)
    begin
      q(3'(s), `SSS_QUAL_MAX, s < 2 ? VMX : IMX);
      q(3'(s), `SSS_QUAL_MIN, s < 2 ? VMN : IMN);
    end
    a = rnd();
    b = rnd();
    t = rnd();
    u = rnd();
    c(`SSS_CMD_VOLT, a);
    c(`SSS_CMD_CURR, b);
    q(`SSS_Q_TRIGGERED_VOLTAGE_COMMAND, `SSS_QUAL_NONE, a);
    q(`SSS_Q_TRIGGERED_CURRENT_COMMAND, `SSS_QUAL_NONE, b);
    c(`SSS_CMD_TRIGGERED_VOLTAGE_COMMAND, t);
    q(`SSS_Q_TRIGGERED_VOLTAGE_COMMAND, `SSS_QUAL_NONE, a);
    c(`SSS_CMD_INIT, 16'h0);
    c(`SSS_CMD_TRIGGERED_VOLTAGE_COMMAND, t);
    c(`SSS_CMD_TRIGGERED_CURRENT_COMMAND, u);
    c(`SSS_CMD_VOLT, b);
    waitv(b, 1'b0);
    q(`SSS_Q_TRIGGERED_VOLTAGE_COMMAND, `SSS_QUAL_NONE, t);
    c(`SSS_CMD_TRIG, 16'h0);
    waitv(t, 1'b0);
    `CHK("current_setpoint", u, iset)
    c(`SSS_CMD_VOLT, a);
    c(`SSS_CMD_INIT, 16'h0);
    c(`SSS_CMD_TRIGGERED_VOLTAGE_COMMAND, u);
    c(`SSS_CMD_ABORT, 16'h0);
    q(`SSS_Q_TRIGGERED_VOLTAGE_COMMAND, `SSS_QUAL_NONE, a);
    c(`SSS_CMD_TRIG, 16'h0);
    repeat (4) @(posedge ref_clk);
    `CHK("voltage_setpoint", a, vset)
    // Continuous initiate keeps the trigger system armed across triggers
    init_cont <= 1'b1;
    c(`SSS_CMD_TRIGGERED_VOLTAGE_COMMAND, b);
    c(`SSS_CMD_TRIG, 16'h0);
    waitv(b, 1'b0);
    c(`SSS_CMD_TRIGGERED_VOLTAGE_COMMAND, t);
    q(`SSS_Q_TRIGGERED_VOLTAGE_COMMAND, `SSS_QUAL_NONE, t);
    init_cont <= 1'b0;
    c(`SSS_CMD_ABORT, 16'h0);
    // Wrap past the last location onto a holding location
    prog(7'h0, a, `SSS_PER_HOLD, 1'b0);
    prog(7'h63, b, 16'h0001, 1'b1);
    c(`SSS_CMD_VOLT, t);
    c(`SSS_CMD_START, 16'h0);
    waitv(b, 1'b0);
    waitv(a, 1'b0);
    repeat (60) @(posedge ref_clk);
    `CHK("voltage_setpoint", a, vset)
    `CHK("output_enable", 1'b1, output_enable)
    q(`SSS_Q_MEM, `SSS_QUAL_NONE, 16'h0);
    c(`SSS_CMD_STOP, 16'h0);
    waitv(16'h0, 1'b1);
    // Jump to location zero, whose zero period stops the run
    prog(7'h0, b, `SSS_PER_STOP, 1'b0);
    prog(7'h5, a, `SSS_PER_WRAP, 1'b1);
    c(`SSS_CMD_VOLT, t);
    c(`SSS_CMD_START, 16'h0);
    waitv(a, 1'b0);
    waitv(16'h0, 1'b1);
    q(`SSS_Q_MEM, `SSS_QUAL_NONE, 16'h0);
    c(`SSS_CMD_STORE, 16'h0);
    ce(`SSS_CMD_MEM, 16'd99, 1'b0);
    ce(`SSS_CMD_MEM, 16'd100, 1'b1);
    @(posedge ref_clk);
    local_mode <= 1'b1;
    ce(`SSS_CMD_MEM, 16'd10, 1'b1);
    ce(`SSS_CMD_MEM, 16'd9, 1'b0);
    q(`SSS_Q_MEM, `SSS_QUAL_NONE, 16'd9);
    @(posedge ref_clk);
    local_mode <= 1'b0;
    repeat (4)
    begin
      @(posedge ref_clk);
      flags <= 8'($urandom);
      meas_voltage <= 16'($urandom % 32'h3fff);
      meas_current <= 16'($urandom % 32'h3fff);
      repeat (8) @(posedge ref_clk);
      #1;
      eo = {4'h0, flags[4], flags[7:5], 1'b0, flags[4], 1'b0, flags[3:0],
        1'b0};
      `CHK("operation", eo, oper & 16'hfffe)
    end
    // Over-voltage then over-current trip, latch and clear
    for (int k = 0; k < 2; k++)
    begin
      c(k ? `SSS_CMD_OCT : `SSS_CMD_OVT, 16'h4000);
      ce(`SSS_CMD_START, 16'h0, 1'b0);
      waitv(16'h1, 1'b1);
      @(posedge ref_clk);
      if (k) meas_current <= 16'h4001; else meas_voltage <= 16'h4001;
      waitv(16'h0, 1'b1);
      repeat (3) @(posedge ref_clk);
      `CHK("questionable", 16'h1 << k, ques)
      ce(`SSS_CMD_START, 16'h0, 1'b1);
      @(posedge ref_clk);
      meas_voltage <= 16'h0;
      meas_current <= 16'h0;
      repeat (10) @(posedge ref_clk);
      `CHK("questionable", 16'h1 << k, ques)
      c(`SSS_CMD_CLEAR, 16'h0);
      repeat (4) @(posedge ref_clk);
      `CHK("questionable", 16'h0, ques)
      ce(`SSS_CMD_START, 16'h0, 1'b0);
      waitv(16'h1, 1'b1);
      c(`SSS_CMD_STOP, 16'h0);
    end
    repeat (4) @(posedge ref_clk);
    conclude();
  end
endmodule // tb_supply_setpoint_sequencer
bind sss_core sss_core_monitor #(.V_MAX(V_MAX)) sss_core_monitor_i (.ref_clk,
  .rst_n, .cmd_valid, .cmd_code, .cmd_value, .qry_valid, .qry_qual, .qry_sel,
  .local_mode, .soft_start_flag, .qry_ready, .qry_data, .cmd_error,
  .voltage_setpoint, .output_enable, .questionable_condition_status,
  .operation_condition_status);
